// ===== verilog/dif_pkg.sv
// constants shared by the interpolation filter control block
// How it works
// - mute low: mid-scale 1.5 clocks after sync
// - bypass low, reset low: plain DAC
// - bypass high, reset low: mid-scale per clock
// - bypass low, reset high: unfiltered, filter runs
// - filtered: first load, then every 16/N clocks
// - strap pins pick ratio 2, 4, 8, 16
// - mute acts at the next output update
// - serial path and filter keep running muted
// - after unmute load the next due value
// - bypass: latch fed from temporary word
// - no bypass, reset high: latch fed only from filter
// - filter keeps computing during bypass
// - filter reset clears and freezes filter at once
// - filter reset leaves serial path alone
// - reset shows mid-scale only with bypass high
// - frame not 16 clocks: automatic filter reset
// - both low: filter off, unfiltered conversion
// - shift MSB first, capture on sync fall
// - squared length-N moving average interpolator
// - missing early inputs taken as mid-scale
// - filtered output lags input two frames
package dif_pkg;
    localparam logic [15:0] MID_CODE = 16'h8000;
    localparam logic [4:0] FRAME_RISES = 5'h10;
    localparam logic [4:0] FIRST_UPD_RISE = 5'h02;
    localparam logic [4:0] RISE_SAT = 5'h1F;
    localparam logic [4:0] PHASE_IDLE = 5'h10;
    localparam logic [3:0] STEP_MASK_BASE = 4'h7;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] BADCNT_OFF = 8'h08;
    localparam int CTRL_SOFT_MUTE = 0;
    localparam int STATUS_BAD_FRAME = 19;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [15:0] BADCNT_RST = 16'h0000;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
endpackage

// ===== verilog/dif_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dif_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    meta_ff[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= d[i];
                    q[i] <= meta_ff[i];
                end
            end
        end
    endgenerate
endmodule

// ===== verilog/dif_filter.sv
// second-order comb interpolator built from running sums
`timescale 1ns/1ps
module dif_filter (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic tick,
    input wire logic load,
    input wire logic [15:0] word,
    input wire logic [1:0] ratio,
    output logic [15:0] y
);
    logic [15:0] xc_ff, xp_ff, xpp_ff;
    logic [25:0] s1_ff, s1o_ff, s2_ff;
    logic init_ff;
    logic [15:0] nxt_xc, nxt_xp, nxt_xpp;
    logic [25:0] nxt_s1, nxt_s1o, nxt_s2, ysh, mid_w;
    logic [2:0] lg;
    // shift reaches 8 at ratio 16, one bit more than lg needs
    logic [3:0] sh;

    assign lg = {1'b0, ratio} + 3'h1;
    assign sh = {1'b0, ratio, 1'b0} + 4'h2;
    assign mid_w = {10'h000, dif_pkg::MID_CODE};
    // new word enters on the first update of a frame
    assign nxt_xc = load ? word : xc_ff;
    assign nxt_xp = load ? xc_ff : xp_ff;
    assign nxt_xpp = load ? xp_ff : xpp_ff;
    // hold, then two length-N sums; feedback form needs exactly 16 clocks a frame
    assign nxt_s1 = tick ? s1_ff + {10'h000, nxt_xc} - {10'h000, nxt_xp} : s1_ff;
    assign nxt_s1o = tick ? s1o_ff + {10'h000, nxt_xp} - {10'h000, nxt_xpp} : s1o_ff;
    assign nxt_s2 = tick ? s2_ff + nxt_s1 - nxt_s1o : s2_ff;
    assign ysh = nxt_s2 >> sh;
    assign y = ysh[15:0];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            xc_ff <= 16'h0000;
            xp_ff <= 16'h0000;
            xpp_ff <= 16'h0000;
            s1_ff <= 26'h000_0000;
            s1o_ff <= 26'h000_0000;
            s2_ff <= 26'h000_0000;
            init_ff <= 1'b0;
        end else if (clr) begin
            xc_ff <= 16'h0000;
            xp_ff <= 16'h0000;
            xpp_ff <= 16'h0000;
            s1_ff <= 26'h000_0000;
            s1o_ff <= 26'h000_0000;
            s2_ff <= 26'h000_0000;
            init_ff <= 1'b0;
        end else if (!init_ff) begin
            xc_ff <= dif_pkg::MID_CODE;
            xp_ff <= dif_pkg::MID_CODE;
            xpp_ff <= dif_pkg::MID_CODE;
            s1_ff <= mid_w << lg;
            s1o_ff <= mid_w << lg;
            s2_ff <= mid_w << sh;
            init_ff <= 1'b1;
        end else begin
            xc_ff <= nxt_xc;
            xp_ff <= nxt_xp;
            xpp_ff <= nxt_xpp;
            s1_ff <= nxt_s1;
            s1o_ff <= nxt_s1o;
            s2_ff <= nxt_s2;
        end
    end

    clear_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clr |=> (s2_ff == 26'h000_0000) && !init_ff)
        else $error("filter not cleared after clear request");
    init_mid_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !init_ff && !clr |=> (xpp_ff == dif_pkg::MID_CODE) && (y == dif_pkg::MID_CODE))
        else $error("filter did not start at mid-scale");
endmodule

// ===== verilog/dif_top.sv
// serial word input, oversampling control and output latch of the interpolating DAC
`timescale 1ns/1ps
module dif_top (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic bit_clk,
    input wire logic word_sync,
    input wire logic serial_in,
    input wire logic filter_bypass_n,
    input wire logic filter_reset_n,
    input wire logic ratio_sel_hi,
    input wire logic ratio_sel_lo,
    input wire logic mute_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] dac_code,
    output logic dac_strobe
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge finding
    logic [6:0] pin_raw, pin_s;
    logic s_bclk, s_ws, s_sin, s_byp_n, s_osr_hi, s_osr_lo, s_mute_n;
    logic bclk_d_ff, ws_d_ff;
    logic rise, wfall;

    assign pin_raw = {bit_clk, word_sync, serial_in, filter_bypass_n, ratio_sel_hi,
                      ratio_sel_lo, mute_n};

    dif_sync #(.W(7)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .d(pin_raw),
        .q(pin_s)
    );

    assign s_bclk = pin_s[6];
    assign s_ws = pin_s[5];
    assign s_sin = pin_s[4];
    assign s_byp_n = pin_s[3];
    assign s_osr_hi = pin_s[2];
    assign s_osr_lo = pin_s[1];
    assign s_mute_n = pin_s[0];
    assign rise = s_bclk & ~bclk_d_ff;
    assign wfall = ~s_ws & ws_d_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bclk_d_ff <= 1'b0;
            ws_d_ff <= 1'b0;
        end else begin
            bclk_d_ff <= s_bclk;
            ws_d_ff <= s_ws;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // filter reset: asserts at once, releases on the clock
    logic frst_raw_n, frst_meta_ff, frst_ff;

    assign frst_raw_n = resetn & filter_reset_n;

    always_ff @(posedge sys_clk or negedge frst_raw_n) begin
        if (!frst_raw_n) begin
            frst_meta_ff <= 1'b0;
            frst_ff <= 1'b0;
        end else begin
            frst_meta_ff <= 1'b1;
            frst_ff <= frst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial path, never touched by the filter reset
    logic [15:0] shift_ff, temp_ff;
    logic [4:0] rcnt_ff, nxt_rcnt;
    logic framed_ff, skip_ff, auto_rst_ff;
    logic bad_frame;

    assign nxt_rcnt = wfall ? {4'h0, rise} :
                      (rise && rcnt_ff != dif_pkg::RISE_SAT) ? rcnt_ff + 5'h01 : rcnt_ff;
    assign bad_frame = wfall && framed_ff && !skip_ff && (rcnt_ff != dif_pkg::FRAME_RISES);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shift_ff <= 16'h0000;
            temp_ff <= 16'h0000;
            // saturated count: no first update before the first sync fall
            rcnt_ff <= dif_pkg::RISE_SAT;
        end else begin
            if (rise) begin
                shift_ff <= {shift_ff[14:0], s_sin};
            end
            if (wfall) begin
                temp_ff <= shift_ff;
            end
            rcnt_ff <= nxt_rcnt;
        end
    end

    // first frame and the frame in which the filter reset lifts are not judged
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            framed_ff <= 1'b0;
            skip_ff <= 1'b1;
            auto_rst_ff <= 1'b0;
        end else begin
            framed_ff <= framed_ff | wfall;
            skip_ff <= !frst_ff | (skip_ff & !wfall);
            auto_rst_ff <= bad_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ratio strap and update schedule
    logic [1:0] ratio_ff;
    logic [3:0] step_mask;
    logic [4:0] ph_ff, ph_inc;
    logic first_upd, mid_tick, tick;

    assign step_mask = dif_pkg::STEP_MASK_BASE >> ratio_ff;
    assign ph_inc = ph_ff + 5'h01;
    assign first_upd = rise && (nxt_rcnt == dif_pkg::FIRST_UPD_RISE);
    assign mid_tick = rise && !first_upd && (ph_inc < dif_pkg::FRAME_RISES)
                      && ((ph_inc[3:0] & step_mask) == 4'h0);
    assign tick = first_upd | mid_tick;

    // ratio only follows the straps while the filter is held in reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ratio_ff <= 2'h0;
            ph_ff <= dif_pkg::PHASE_IDLE;
        end else begin
            if (!frst_ff) begin
                ratio_ff <= {s_osr_hi, s_osr_lo};
            end
            if (first_upd) begin
                ph_ff <= 5'h00;
            end else if (rise && ph_ff < dif_pkg::PHASE_IDLE) begin
                ph_ff <= ph_inc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // filter, runs regardless of bypass and mute
    logic [15:0] filt_y;

    dif_filter u_filter (
        .sys_clk(sys_clk),
        .arst_n(frst_ff),
        .clr(auto_rst_ff),
        .tick(tick),
        .load(first_upd),
        .word(temp_ff),
        .ratio(ratio_ff),
        .y(filt_y)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // output latch selection
    logic soft_mute_ff, mute_eff, bypass_sel, upd;
    logic [15:0] dac_ff, nxt_dac;
    logic strobe_ff;

    // register mute is ored in, so it also waits for the next update
    assign mute_eff = !s_mute_n | soft_mute_ff;
    assign bypass_sel = !s_byp_n;
    // in filter reset with bypass high every bit clock rise reloads mid-scale
    assign upd = bypass_sel ? first_upd : (frst_ff ? tick : rise);
    assign nxt_dac = mute_eff ? dif_pkg::MID_CODE :
                     bypass_sel ? temp_ff :
                     frst_ff ? filt_y : dif_pkg::MID_CODE;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dac_ff <= dif_pkg::MID_CODE;
            strobe_ff <= 1'b0;
        end else begin
            if (upd) begin
                dac_ff <= nxt_dac;
            end
            strobe_ff <= upd;
        end
    end

    assign dac_code = dac_ff;
    assign dac_strobe = strobe_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave, no wait states
    logic hit_ctrl, hit_status, hit_badcnt, hit_any;
    logic wr_acc, rd_setup, clr_bad;
    logic bad_sticky_ff;
    logic [15:0] badcnt_ff;
    logic [31:0] status_word, rd_word, prdata_ff;

    assign hit_ctrl = (paddr == dif_pkg::CTRL_OFF);
    assign hit_status = (paddr == dif_pkg::STATUS_OFF);
    assign hit_badcnt = (paddr == dif_pkg::BADCNT_OFF);
    assign hit_any = hit_ctrl | hit_status | hit_badcnt;
    assign wr_acc = psel & penable & pwrite & hit_any;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign clr_bad = wr_acc & hit_status & pwdata[dif_pkg::STATUS_BAD_FRAME];
    assign status_word = {12'h000, bad_sticky_ff, frst_ff, ratio_ff, dac_ff};
    assign rd_word = hit_ctrl ? {31'h0000_0000, soft_mute_ff} :
                     hit_status ? status_word :
                     hit_badcnt ? {16'h0000, badcnt_ff} : dif_pkg::PRDATA_RST;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata = prdata_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            soft_mute_ff <= dif_pkg::CTRL_RST;
            bad_sticky_ff <= 1'b0;
            badcnt_ff <= dif_pkg::BADCNT_RST;
            prdata_ff <= dif_pkg::PRDATA_RST;
        end else begin
            if (wr_acc && hit_ctrl) begin
                soft_mute_ff <= pwdata[dif_pkg::CTRL_SOFT_MUTE];
            end
            // a bad frame in the clearing cycle keeps the flag set
            bad_sticky_ff <= auto_rst_ff | (bad_sticky_ff & ~clr_bad);
            if (auto_rst_ff) begin
                badcnt_ff <= badcnt_ff + 16'h0001;
            end
            if (rd_setup) begin
                prdata_ff <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checking helpers: ticks and rises between frame loads
    logic [4:0] tick_since_ff, rise_since_ff;
    logic seen_first_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_since_ff <= 5'h00;
            rise_since_ff <= 5'h00;
            seen_first_ff <= 1'b0;
        end else if (first_upd) begin
            tick_since_ff <= 5'h01;
            rise_since_ff <= 5'h01;
            seen_first_ff <= frst_ff;
        end else begin
            tick_since_ff <= tick_since_ff + {4'h0, mid_tick};
            rise_since_ff <= rise_since_ff + {4'h0, rise && rise_since_ff != dif_pkg::RISE_SAT};
        end
    end

    mute_mid_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        first_upd && mute_eff |=> dac_strobe && (dac_code == dif_pkg::MID_CODE))
        else $error("muted update did not give mid-scale");
    bypass_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        first_upd && bypass_sel && !mute_eff |=> dac_code == $past(temp_ff))
        else $error("bypass update did not take the temporary word");
    bypass_time_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        dac_strobe && $past(bypass_sel) |-> rcnt_ff == 5'h02)
        else $error("bypass update not on second bit clock rise");
    filt_only_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        tick && frst_ff && !bypass_sel && !mute_eff |=> dac_code == $past(filt_y))
        else $error("filtered update did not take the filter output");
    init_mid_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rise && !frst_ff && !bypass_sel && !mute_eff |=> dac_strobe
        && (dac_code == dif_pkg::MID_CODE))
        else $error("filter reset did not drive mid-scale");
    auto_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wfall && framed_ff && !skip_ff && (rcnt_ff != 5'h10) |=> auto_rst_ff ##1 !auto_rst_ff)
        else $error("odd frame length without one auto reset pulse");
    tick_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        first_upd && seen_first_ff && frst_ff && (rise_since_ff == 5'h10)
        |-> tick_since_ff == (5'h02 << ratio_ff))
        else $error("wrong number of updates per frame");
    ratio_strap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !frst_ff |=> ratio_ff == $past({s_osr_hi, s_osr_lo}))
        else $error("ratio strap not followed during filter reset");
    shift_on_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rise && !frst_ff |=> shift_ff[0] == $past(s_sin))
        else $error("serial path stalled by filter reset");
    shift_muted_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rise && mute_eff |=> shift_ff[0] == $past(s_sin))
        else $error("serial path stalled by mute");
    capture_word_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wfall |=> temp_ff == $past(shift_ff))
        else $error("sync fall did not capture the shift register");
    sticky_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        auto_rst_ff |=> bad_sticky_ff)
        else $error("bad frame flag not set by auto reset");
    bad_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        auto_rst_ff |=> badcnt_ff == $past(badcnt_ff) + 16'h0001)
        else $error("bad frame count did not step");
    filter_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !filter_reset_n |-> !frst_ff)
        else $error("filter not held while its reset pin is low");
    reset_mid_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        dac_strobe && $past(!frst_ff && !bypass_sel) |-> dac_code == dif_pkg::MID_CODE)
        else $error("filter reset with bypass high did not give mid-scale");
endmodule

// ===== tb/dif_host_model.sv
// host model sending continuous serial frames to the filter control block
`timescale 1ns/1ps
module dif_host_model (
    input wire logic [15:0] word,
    input wire logic [4:0] nrise,
    output logic bit_clk,
    output logic word_sync,
    output logic serial_in
);
    logic [15:0] w;
    int n;
    initial begin
        // pins low until power-up is over
        bit_clk = 1'b0;
        word_sync = 1'b0;
        serial_in = 1'b0;
        #1007;
        // 5 MHz bit clock: even ratio 16 stays far below the update limit
        forever begin
            #50;
            w = word;
            n = int'(nrise);
            for (int i = 0; i < n; i++) begin
                if (i > 0) begin
                    #50;
                end
                // msb first; bits past the sixteenth only toggle
                serial_in = (i < 16) ? w[15 - i] : ~serial_in;
                #50 bit_clk = 1'b1;
                #100 bit_clk = 1'b0;
                if (i == 0) begin
                    word_sync = 1'b1;
                end
                if (i == n - 1) begin
                    word_sync = 1'b0;
                end
            end
        end
    end
endmodule

// ===== tb/dif_top_tb.sv
// self-checking bench for the interpolation filter control block
`timescale 1ns/1ps
module dif_top_tb;
    logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, dac_strobe, er;
    logic filter_bypass_n, filter_reset_n, ratio_sel_hi, ratio_sel_lo, mute_n;
    logic bit_clk, word_sync, serial_in, use_fix, free_mode, zero_cnt;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, b0;
    logic [15:0] dac_code, cur, fix_w, host_word, last_code, w0;
    logic [4:0] host_nrise, nr_next;
    logic [15:0] exp_q[$];
    int err_count, num_checks, st_cnt, snap;

    dif_host_model i_host (.word(host_word), .nrise(host_nrise), .bit_clk(bit_clk),
        .word_sync(word_sync), .serial_in(serial_in));
    dif_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .bit_clk(bit_clk),
        .word_sync(word_sync), .serial_in(serial_in), .filter_bypass_n(filter_bypass_n),
        .filter_reset_n(filter_reset_n), .ratio_sel_hi(ratio_sel_hi),
        .ratio_sel_lo(ratio_sel_lo), .mute_n(mute_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dac_code(dac_code), .dac_strobe(dac_strobe));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", 32'h0000_0001, 32'h0000_0000);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // mode pins change just after a sync fall, long before the update it governs
    task automatic frame(input logic bp, input logic rs, input logic mt, input int kind);
        logic [15:0] prev;
        @(negedge word_sync);
        snap = st_cnt;
        if (zero_cnt) begin
            st_cnt = 0;
        end
        zero_cnt = 1'b0;
        if (kind == 2) begin
            free_mode = 1'b1;
        end
        host_nrise = nr_next;
        nr_next = dif_pkg::FRAME_RISES;
        prev = cur;
        cur = use_fix ? fix_w : xs();
        host_word = cur;
        @(posedge sys_clk);
        filter_bypass_n <= bp;
        filter_reset_n <= rs;
        mute_n <= mt;
        if (kind == 0) begin
            exp_q.push_back(prev);
        end
        if (kind == 1) begin
            exp_q.push_back(dif_pkg::MID_CODE);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (dac_strobe === 1'b1 && free_mode) begin
            st_cnt++;
            last_code = dac_code;
        end else if (dac_strobe === 1'b1 && exp_q.size() == 0) begin
            chk("dac_strobe", 32'h0000_0000, 32'h0000_0001);
        end else if (dac_strobe === 1'b1) begin
            chk("dac_code", 32'(exp_q.pop_front()), 32'(dac_code));
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        #400us;
        err_count++;
        summarize();
    end

    initial begin
        seed = 32'h0000_611a;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {filter_bypass_n, filter_reset_n, ratio_sel_hi, ratio_sel_lo, mute_n} = '0;
        resetn = 1'b0;
        {err_count, num_checks, st_cnt, snap} = '0;
        {use_fix, free_mode, zero_cnt, fix_w, last_code} = '0;
        nr_next = dif_pkg::FRAME_RISES;
        host_nrise = dif_pkg::FRAME_RISES;
        cur = xs();
        host_word = cur;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        apb(1'b0, dif_pkg::CTRL_OFF, '0);
        chk("ctrl_rst", 32'(dif_pkg::CTRL_RST), rd);
        apb(1'b0, dif_pkg::BADCNT_OFF, '0);
        chk("badcnt_rst", 32'(dif_pkg::BADCNT_RST), rd);
        apb(1'b0, 8'h0c, '0);
        chk("unmapped_err", 32'h0000_0001, 32'(er));
        chk("unmapped_data", 32'h0000_0000, rd);
        repeat (4) frame(1'b0, 1'b0, 1'b1, 0);
        repeat (3) frame(1'b0, 1'b1, 1'b1, 0);
        repeat (3) frame(1'b0, 1'b1, 1'b0, 1);
        repeat (2) frame(1'b0, 1'b1, 1'b1, 0);
        frame(1'b0, 1'b1, 1'b1, 1);
        apb(1'b1, dif_pkg::CTRL_OFF, 32'h0000_0001);
        apb(1'b0, dif_pkg::CTRL_OFF, '0);
        chk("ctrl_mute", 32'h0000_0001, rd);
        frame(1'b0, 1'b1, 1'b1, 0);
        apb(1'b1, dif_pkg::CTRL_OFF, '0);
        frame(1'b1, 1'b0, 1'b1, 2);
        chk("pending", 32'h0000_0000, 32'(exp_q.size()));
        frame(1'b1, 1'b0, 1'b1, 2);
        zero_cnt = 1'b1;
        repeat (3) frame(1'b1, 1'b0, 1'b1, 2);
        chk("init_count", 32'd32, 32'(snap));
        chk("init_code", 32'(dif_pkg::MID_CODE), 32'(last_code));
        for (int r = 0; r < 4; r++) begin
            w0 = xs();
            fix_w = w0;
            use_fix = 1'b1;
            frame(1'b0, 1'b0, 1'b1, 2);
            {ratio_sel_hi, ratio_sel_lo} <= r[1:0];
            frame(1'b0, 1'b1, 1'b1, 2);
            repeat (5) frame(1'b1, 1'b1, 1'b1, 2);
            zero_cnt = 1'b1;
            repeat (3) frame(1'b1, 1'b1, 1'b1, 2);
            chk("filt_count", 32'((2 << r) * 2), 32'(snap));
            chk("filt_code", 32'(w0), 32'(last_code));
            apb(1'b0, dif_pkg::STATUS_OFF, '0);
            chk("status_ratio", 32'(r), {30'h0000_0000, rd[17:16]});
        end
        apb(1'b0, dif_pkg::BADCNT_OFF, '0);
        b0 = rd;
        apb(1'b1, dif_pkg::STATUS_OFF, 32'h0008_0000);
        nr_next = 5'h0f;
        repeat (4) frame(1'b1, 1'b1, 1'b1, 2);
        apb(1'b0, dif_pkg::BADCNT_OFF, '0);
        chk("bad_count", b0 + 32'h0000_0001, rd);
        apb(1'b0, dif_pkg::STATUS_OFF, '0);
        chk("bad_flag", 32'h0000_0001, 32'(rd[dif_pkg::STATUS_BAD_FRAME]));
        apb(1'b1, dif_pkg::STATUS_OFF, 32'h0008_0000);
        apb(1'b0, dif_pkg::STATUS_OFF, '0);
        chk("bad_clear", 32'h0000_0000, 32'(rd[dif_pkg::STATUS_BAD_FRAME]));
        summarize();
    end
endmodule
